// >>> hdl/sbs_status.sv
// Secondary bus status register with sticky error flags
`timescale 1ns/1ps
`default_nettype none
`include "sbs_params.svh"
module sbs_status #(
  parameter int ADDR_W = 8
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [ADDR_W-1:0] CFG_ADDR,
  input wire logic CFG_RD,
  input wire logic CFG_WR,
  input wire logic [1:0] CFG_BE,
  input wire logic [15:0] CFG_WDATA,
  output logic [15:0] CFG_RDATA,
  output logic CFG_RVALID,
  input wire logic SERR_N,
  input wire logic HIGH_FREQ_ENABLE_PIN,
  input wire logic MASTER_ABORT_PULSE,
  input wire logic TARGET_ABORT_RCVD_PULSE,
  input wire logic TARGET_ABORT_SENT_PULSE,
  input wire logic MASTER_ACTIVE,
  input wire logic MASTER_READ,
  input wire logic PERR_DRIVEN_PULSE,
  input wire logic PERR_SEEN_PULSE,
  input wire logic PARITY_RESPONSE_ENABLE,
  input wire logic PARITY_FAULT_PULSE,
  output logic [15:0] SEC_STATUS
);
  import sbs_pkg::*;

  // ==========================================================
  // Elaboration check
  if (ADDR_W < 8) begin : g_bad_addr
    $error("sbs_status needs at least eight address bits");
  end

  // ==========================================================
  // Pin synchronisers
  logic [1:0] pins_sync;
  logic serr_n_s;
  logic high_freq_s;

  // SERR idles high, so the stages reset to the idle level
  sbs_sync #(
    .WIDTH(2),
    .RESET_VAL(2'h1)
  ) u_pin_sync (
    .clk(CLK),
    .rst(RST),
    .async_in({HIGH_FREQ_ENABLE_PIN, SERR_N}),
    .sync_out(pins_sync)
  );

  assign serr_n_s = pins_sync[0];
  assign high_freq_s = pins_sync[1];

  // ==========================================================
  // Decode and event collection
  logic hit;
  logic wr_hit;
  logic rd_hit;
  logic mpar_cond;
  logic [5:0] set_vec;
  logic [5:0] clr_vec;

  // Only the low address byte is compared with the status word offset; any upper address bits are ignored
  assign hit = (CFG_ADDR[7:0] == `SBS_STATUS_OFS);
  assign wr_hit = CFG_WR && hit;
  assign rd_hit = CFG_RD && hit;

  assign mpar_cond = MASTER_ACTIVE && PARITY_RESPONSE_ENABLE &&
                     ((MASTER_READ && PERR_DRIVEN_PULSE) || (!MASTER_READ && PERR_SEEN_PULSE));

  // Event vector in flag order
  always_comb begin
    set_vec = '0;
    set_vec[SBS_F_MPAR] = mpar_cond;
    set_vec[SBS_F_TABSIG] = TARGET_ABORT_SENT_PULSE;
    set_vec[SBS_F_TABREC] = TARGET_ABORT_RCVD_PULSE;
    set_vec[SBS_F_MTERM] = MASTER_ABORT_PULSE;
    set_vec[SBS_F_SYSERR] = !serr_n_s;
    set_vec[SBS_F_DETPAR] = PARITY_FAULT_PULSE;
  end

  // write-one clears, high byte lane only holds flags
  always_comb begin
    clr_vec = '0;
    if (wr_hit && CFG_BE[1]) begin
      clr_vec[SBS_F_MPAR] = CFG_WDATA[`SBS_POS_MPAR];
      clr_vec[SBS_F_TABSIG] = CFG_WDATA[`SBS_POS_TABSIG];
      clr_vec[SBS_F_TABREC] = CFG_WDATA[`SBS_POS_TABREC];
      clr_vec[SBS_F_MTERM] = CFG_WDATA[`SBS_POS_MTERM];
      clr_vec[SBS_F_SYSERR] = CFG_WDATA[`SBS_POS_SYSERR];
      clr_vec[SBS_F_DETPAR] = CFG_WDATA[`SBS_POS_DETPAR];
    end
  end

  // ==========================================================
  // State update
  sbs_state_t state_r;
  sbs_state_t state_nxt;

  // Set wins over a clear in the same cycle so no event is lost
  always_comb begin
    state_nxt = state_r;
    state_nxt.flags = (state_r.flags & ~clr_vec) | set_vec;
    state_nxt.status = '0;
    state_nxt.status[`SBS_POS_DETPAR] = state_nxt.flags[SBS_F_DETPAR];
    state_nxt.status[`SBS_POS_SYSERR] = state_nxt.flags[SBS_F_SYSERR];
    state_nxt.status[`SBS_POS_MTERM] = state_nxt.flags[SBS_F_MTERM];
    state_nxt.status[`SBS_POS_TABREC] = state_nxt.flags[SBS_F_TABREC];
    state_nxt.status[`SBS_POS_TABSIG] = state_nxt.flags[SBS_F_TABSIG];
    state_nxt.status[`SBS_POS_DEVSEL_HI:`SBS_POS_DEVSEL_LO] = `SBS_DEVSEL_MEDIUM;
    state_nxt.status[`SBS_POS_MPAR] = state_nxt.flags[SBS_F_MPAR];
    state_nxt.status[`SBS_POS_FBB] = `SBS_FBB_VALUE;
    state_nxt.status[`SBS_POS_RSVD6] = `SBS_RSVD6_VALUE;
    state_nxt.status[`SBS_POS_HIFREQ] = high_freq_s;
    state_nxt.status[`SBS_POS_RSVD_HI:0] = `SBS_RSVD_LOW_VALUE;
    // Read returns the word as it stood when the read was taken
    state_nxt.rvalid = CFG_RD;
    state_nxt.rdata = rd_hit ? state_r.status : 16'h0000;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r.flags <= 6'h00;
      state_r.status <= `SBS_RESET_VALUE;
      state_r.rdata <= 16'h0000;
      state_r.rvalid <= 1'h0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from the state flops
  assign SEC_STATUS = state_r.status;
  assign CFG_RDATA = state_r.rdata;
  assign CFG_RVALID = state_r.rvalid;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_read_taken;
    CFG_RD && hit;
  endsequence

  sequence s_serr_seen;
    !serr_n_s;
  endsequence

  sequence s_clear_only(int pos);
    wr_hit && CFG_BE[1] && CFG_WDATA[pos];
  endsequence

  property p_syserr_set;
    s_serr_seen |=> SEC_STATUS[`SBS_POS_SYSERR];
  endproperty
  a_syserr_set: assert property (p_syserr_set) else $error("system error flag not set");

  property p_mterm_set;
    MASTER_ABORT_PULSE |=> SEC_STATUS[`SBS_POS_MTERM] && state_r.flags[SBS_F_MTERM];
  endproperty
  a_mterm_set: assert property (p_mterm_set) else $error("master abort flag not set");

  property p_tabrec_set;
    TARGET_ABORT_RCVD_PULSE |=> SEC_STATUS[`SBS_POS_TABREC];
  endproperty
  a_tabrec_set: assert property (p_tabrec_set) else $error("received target abort flag not set");

  property p_tabsig_set;
    TARGET_ABORT_SENT_PULSE |=> SEC_STATUS[`SBS_POS_TABSIG];
  endproperty
  a_tabsig_set: assert property (p_tabsig_set) else $error("sent target abort flag not set");

  property p_devsel;
    SEC_STATUS[`SBS_POS_DEVSEL_HI:`SBS_POS_DEVSEL_LO] == `SBS_DEVSEL_MEDIUM;
  endproperty
  a_devsel: assert property (p_devsel) else $error("decode timing field wrong");

  property p_mpar_cause;
    $rose(SEC_STATUS[`SBS_POS_MPAR]) |-> $past(mpar_cond);
  endproperty
  a_mpar_cause: assert property (p_mpar_cause) else $error("parity flag set without cause");

  property p_mpar_set;
    mpar_cond |=> SEC_STATUS[`SBS_POS_MPAR];
  endproperty
  a_mpar_set: assert property (p_mpar_set) else $error("parity flag missed");

  property p_fbb_rsvd6;
    SEC_STATUS[`SBS_POS_FBB] && !SEC_STATUS[`SBS_POS_RSVD6];
  endproperty
  a_fbb_rsvd6: assert property (p_fbb_rsvd6) else $error("bit seven or six wrong");

  property p_rsvd_low;
    s_read_taken |=> CFG_RVALID && (CFG_RDATA[`SBS_POS_RSVD_HI:0] == `SBS_RSVD_LOW_VALUE) && !CFG_RDATA[6];
  endproperty
  a_rsvd_low: assert property (p_rsvd_low) else $error("reserved bits read nonzero");

  property p_rsvd6_write;
    wr_hit && CFG_BE[0] && CFG_WDATA[6] |=> !SEC_STATUS[`SBS_POS_RSVD6];
  endproperty
  a_rsvd6_write: assert property (p_rsvd6_write) else $error("reserved bit took a write");

  property p_hifreq;
    ##1 SEC_STATUS[`SBS_POS_HIFREQ] == $past(high_freq_s);
  endproperty
  a_hifreq: assert property (p_hifreq) else $error("frequency bit not following pin");

  property p_detpar_set;
    PARITY_FAULT_PULSE && !PARITY_RESPONSE_ENABLE |=> SEC_STATUS[`SBS_POS_DETPAR];
  endproperty
  a_detpar_set: assert property (p_detpar_set) else $error("detected parity flag missed");

  property p_read_data;
    s_read_taken |=> CFG_RDATA == $past(SEC_STATUS);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data not the status word");

  property p_sticky;
    SEC_STATUS[`SBS_POS_MTERM] && !clr_vec[SBS_F_MTERM] |=> SEC_STATUS[`SBS_POS_MTERM] [*1];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

  property p_clear;
    s_clear_only(`SBS_POS_TABSIG) ##0 !TARGET_ABORT_SENT_PULSE |=> !SEC_STATUS[`SBS_POS_TABSIG];
  endproperty
  a_clear: assert property (p_clear) else $error("write one did not clear flag");

  property p_set_wins;
    s_clear_only(`SBS_POS_TABREC) ##0 TARGET_ABORT_RCVD_PULSE |=> SEC_STATUS[`SBS_POS_TABREC];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a same-cycle event");

  // Every read gets exactly one valid cycle, hit or miss
  property p_rvalid_pulse;
    CFG_RD |=> CFG_RVALID;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read got no valid strobe");

  property p_rvalid_idle;
    !CFG_RD |=> !CFG_RVALID;
  endproperty
  a_rvalid_idle: assert property (p_rvalid_idle) else $error("valid strobe without a read");

  property p_miss_zero;
    CFG_RD && !hit |=> CFG_RDATA == 16'h0000;
  endproperty
  a_miss_zero: assert property (p_miss_zero) else $error("unmapped read returned data");

  // Flags rise only from their own event
  property p_mterm_cause;
    $rose(SEC_STATUS[`SBS_POS_MTERM]) |-> $past(MASTER_ABORT_PULSE);
  endproperty
  a_mterm_cause: assert property (p_mterm_cause) else $error("master abort flag set without cause");

  property p_tabrec_cause;
    $rose(SEC_STATUS[`SBS_POS_TABREC]) |-> $past(TARGET_ABORT_RCVD_PULSE);
  endproperty
  a_tabrec_cause: assert property (p_tabrec_cause) else $error("received abort flag set without cause");

  property p_tabsig_cause;
    $rose(SEC_STATUS[`SBS_POS_TABSIG]) |-> $past(TARGET_ABORT_SENT_PULSE);
  endproperty
  a_tabsig_cause: assert property (p_tabsig_cause) else $error("sent abort flag set without cause");

  property p_mpar_block;
    (!MASTER_ACTIVE || !PARITY_RESPONSE_ENABLE) && !SEC_STATUS[`SBS_POS_MPAR] |=> !SEC_STATUS[`SBS_POS_MPAR];
  endproperty
  a_mpar_block: assert property (p_mpar_block) else $error("parity flag set while gated off");

  property p_detpar_en;
    PARITY_FAULT_PULSE && PARITY_RESPONSE_ENABLE |=> SEC_STATUS[`SBS_POS_DETPAR];
  endproperty
  a_detpar_en: assert property (p_detpar_en) else $error("detected parity flag missed when enabled");

  property p_rsvd_status;
    SEC_STATUS[`SBS_POS_RSVD_HI:0] == `SBS_RSVD_LOW_VALUE;
  endproperty
  a_rsvd_status: assert property (p_rsvd_status) else $error("reserved low bits nonzero");

  // A system error clear only sticks once the synchronised pin is back high
  property p_syserr_clear;
    s_clear_only(`SBS_POS_SYSERR) ##0 serr_n_s |=> !SEC_STATUS[`SBS_POS_SYSERR];
  endproperty
  a_syserr_clear: assert property (p_syserr_clear) else $error("system error flag not cleared");

  // The low byte lane carries no flags, so it can never clear one
  property p_low_lane;
    wr_hit && !CFG_BE[1] && (set_vec == 6'h00) |=> state_r.flags == $past(state_r.flags);
  endproperty
  a_low_lane: assert property (p_low_lane) else $error("low lane write changed a flag");

endmodule : sbs_status
`default_nettype wire

// >>> hdl/sbs_params.svh
// Constants for the secondary bus status register block
// Functional notes
// - A secondary system error assertion sets the received-system-error flag, bit 14.
// - Master abort on our own secondary transaction sets bit 13.
// - Target abort received on our secondary transaction sets bit 12.
// - Target abort signalled by us as secondary target sets bit 11.
// - Decode timing field, bits 10:9, always reads 01b, medium speed.
// - Bit 8 sets when mastering, parity response enabled, and read or write parity fault.
// - Bit 7 always reads 1b, fast back-to-back supported.
// - Reserved bit 6 reads 0b; writes ignored.
// - Reserved bits 4:0 read 00000b; writes ignored.
// - Bit 5 follows the level of the high frequency enable pin.
// - Any uncorrectable secondary parity error sets bit 15, enable or not.
// - Register sits at offset 1Eh; reset shows bits 9 and 7 set, flags clear.
`ifndef SBS_PARAMS_SVH
`define SBS_PARAMS_SVH

// ==========================================================
// Register placement
`define SBS_STATUS_OFS 8'h1E
`define SBS_RESET_VALUE 16'h0280

// ==========================================================
// Field positions
`define SBS_POS_DETPAR 15
`define SBS_POS_SYSERR 14
`define SBS_POS_MTERM 13
`define SBS_POS_TABREC 12
`define SBS_POS_TABSIG 11
`define SBS_POS_DEVSEL_HI 10
`define SBS_POS_DEVSEL_LO 9
`define SBS_POS_MPAR 8
`define SBS_POS_FBB 7
`define SBS_POS_RSVD6 6
`define SBS_POS_HIFREQ 5
`define SBS_POS_RSVD_HI 4

// ==========================================================
// Constant field values and synchroniser depth
`define SBS_DEVSEL_MEDIUM 2'h1
`define SBS_FBB_VALUE 1'h1
`define SBS_RSVD6_VALUE 1'h0
`define SBS_RSVD_LOW_VALUE 5'h00
`define SBS_SYNC_STAGES 2

`endif

// >>> hdl/sbs_pkg.sv
// Types shared by the secondary bus status register block
`default_nettype none
package sbs_pkg;

  // Index of each sticky flag inside the flag vector
  typedef enum logic [2:0] {
    SBS_F_MPAR = 3'h0,
    SBS_F_TABSIG = 3'h1,
    SBS_F_TABREC = 3'h2,
    SBS_F_MTERM = 3'h3,
    SBS_F_SYSERR = 3'h4,
    SBS_F_DETPAR = 3'h5
  } sbs_flag_t;

  // State of the status block apart from the pin synchroniser flops
  typedef struct packed {
    logic [5:0] flags;
    logic [15:0] status;
    logic [15:0] rdata;
    logic rvalid;
  } sbs_state_t;

endpackage : sbs_pkg
`default_nettype wire

// >>> hdl/sbs_sync.sv
// Two-stage synchroniser for the asynchronous pins of the status block
`timescale 1ns/1ps
`default_nettype none
module sbs_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ==========================================================
  // Elaboration check
  if (WIDTH < 1) begin : g_bad_width
    $error("sbs_sync width must be at least one");
  end

  // ==========================================================
  // Per-bit flop pairs; the first stage feeds only the second
  wire logic [WIDTH-1:0] stage_w;
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_r;
    logic stable_r;
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        meta_r <= RESET_VAL[i];
        stable_r <= RESET_VAL[i];
      end else begin
        meta_r <= async_in[i];
        stable_r <= meta_r;
      end
    end
    assign stage_w[i] = stable_r;
  end

  // Bits gather in a net so the output variable has a single driver
  assign sync_out = stage_w;

endmodule : sbs_sync
`default_nettype wire

// >>> dv/sbs_bus_agent.sv
// Secondary bus agent model raising bus events on request
`timescale 1ns/1ps
`default_nettype none
module sbs_bus_agent (
  input wire logic clk,
  input wire logic go,
  input wire logic [2:0] sel,
  input wire logic slow,
  output logic serr_n,
  output logic [5:0] pulse
);
  // ==========================================
  // Event launch, prompt or after a stall
  // Error pin rests high, as its pull-up would hold it
  initial begin
    serr_n = 1'b1;
    pulse = '0;
    forever begin
      @(posedge clk);
      if (go) begin
        repeat (slow ? 3 : 0) @(posedge clk);
        #1;
        if (sel == 3'h0) serr_n = 1'b0;
        else pulse[sel - 3'h1] = 1'b1;
        @(posedge clk);
        #1;
        pulse = '0;
        @(posedge clk);
        #1;
        serr_n = 1'b1;
      end
    end
  end
endmodule : sbs_bus_agent
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the secondary bus status register
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sbs_pkg::*;
  logic clk, rst, rd, wr, go, slow, pin, mact, mrd, pre, rvalid, serr_n;
  logic [7:0] addr;
  logic [1:0] be;
  logic [2:0] sel;
  logic [3:0] c;
  logic [5:0] pulse;
  logic [15:0] wdata, rdata, stat, flags, got, m;
  int errors, num_checks, cyc;

  sbs_status dut (.CLK(clk), .RST(rst), .CFG_ADDR(addr), .CFG_RD(rd), .CFG_WR(wr),
    .CFG_BE(be), .CFG_WDATA(wdata), .CFG_RDATA(rdata), .CFG_RVALID(rvalid),
    .SERR_N(serr_n), .HIGH_FREQ_ENABLE_PIN(pin), .MASTER_ABORT_PULSE(pulse[0]),
    .TARGET_ABORT_RCVD_PULSE(pulse[1]), .TARGET_ABORT_SENT_PULSE(pulse[2]),
    .MASTER_ACTIVE(mact), .MASTER_READ(mrd), .PERR_DRIVEN_PULSE(pulse[5]),
    .PERR_SEEN_PULSE(pulse[4]), .PARITY_RESPONSE_ENABLE(pre),
    .PARITY_FAULT_PULSE(pulse[3]), .SEC_STATUS(stat));
  sbs_bus_agent agent (.clk(clk), .go(go), .sel(sel), .slow(slow), .serr_n(serr_n), .pulse(pulse));

  // ==========================================
  // Clock and hang guard
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      final_report();
    end
  end

  // ==========================================
  // Expectations and bus tasks
  // Flags live at 15:11 and 8; constants and pin folded in
  function automatic logic [15:0] exp_word(input logic [15:0] f, input logic p);
    return (f & 16'hF900) | 16'h0280 | {10'h000, p, 5'h00};
  endfunction : exp_word
  function automatic logic [15:0] ev_mask(input logic [2:0] s);
    return (s == 3'h4) ? 16'h8000 : (16'h4000 >> s);
  endfunction : ev_mask
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Answer stands one cycle, so it is sampled right after the taking edge
  task automatic cfg_read(input logic [7:0] a);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    check({15'h0000, rvalid}, 16'h0001);
    got = rdata;
    tick(1);
  endtask : cfg_read
  // Strobe drops for a full cycle so back-to-back calls never retoggle it
  task automatic cfg_write(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
    addr = a;
    be = b;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask : cfg_write
  // Wait covers the stalled agent plus the pin synchroniser
  task automatic fire(input logic [2:0] s, input logic sl);
    sel = s;
    slow = sl;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    tick(8);
  endtask : fire
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  // ==========================================
  // Main sequence
  initial begin
    {clk, rd, wr, go, slow, mact, mrd, pre, be, sel} = '0;
    {addr, wdata, flags} = '0;
    {rst, pin} = 2'b11;
    errors = 0;
    num_checks = 0;
    cyc = 0;
    void'($urandom(77223));
    repeat (10) @(posedge clk);
    #1;
    check(stat, 16'h0280);
    rst = 1'b0;
    tick(3);
    cfg_read(8'h1E);
    check(got, exp_word(16'h0000, 1'b1));
    cfg_read(8'h1C);
    check(got, 16'h0000);
    $display("test reset done");
    cfg_write(8'h1E, 2'h3, 16'hFFFF);
    check(stat, exp_word(16'h0000, 1'b1));
    pin = 1'b0;
    tick(4);
    check(stat, exp_word(16'h0000, 1'b0));
    pin = 1'b1;
    tick(4);
    $display("test constants done");
    for (int s = 0; s < 10; s++) begin
      fire(s[3:1], s[0]);
      flags = ev_mask(s[3:1]);
      check(stat, exp_word(flags, 1'b1));
      cfg_write(8'h1C, 2'h3, 16'hFFFF);
      cfg_write(8'h1E, 2'h3, ~flags);
      cfg_write(8'h1E, 2'h1, 16'hFFFF);
      check(stat, exp_word(flags, 1'b1));
      cfg_write(8'h1E, 2'h2, flags);
      check(stat, exp_word(16'h0000, 1'b1));
    end
    // Clear taken on the same edge as a new event: the event must survive
    sel = 3'h2;
    slow = 1'b0;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    cfg_write(8'h1E, 2'h2, 16'h1000);
    tick(6);
    check(stat, exp_word(16'h1000, 1'b1));
    cfg_write(8'h1E, 2'h2, 16'h1000);
    $display("test events done");
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      {mact, mrd, pre} = c[3:1];
      fire(c[0] ? 3'h6 : 3'h5, 1'b0);
      flags = (mact && pre && (mrd ? c[0] : !c[0])) ? 16'h0100 : 16'h0000;
      check(stat, exp_word(flags, 1'b1));
      cfg_write(8'h1E, 2'h2, 16'h0100);
    end
    mact = 1'b0;
    flags = '0;
    $display("test parity done");
    for (int i = 0; i < 30; i++) begin
      sel = 3'($urandom_range(4, 0));
      fire(sel, 1'($urandom_range(1, 0)));
      flags = flags | ev_mask(sel);
      m = 16'($urandom);
      cfg_write(8'h1E, 2'h2, m);
      flags = flags & ~m;
      cfg_read(8'h1E);
      check(got, exp_word(flags, 1'b1));
    end
    $display("test random done");
    final_report();
  end
endmodule : tb
`default_nettype wire
